/* File: cpu_status_flag_register.sv */
/*
 * CPU flag and bank-select register with its file-address decode and flag update.
 * It assumes the execution logic issues at most one file write per clock and pulses
 * the watchdog and sleep events for one cycle each; rstn is the power-on reset.
 */
// Functional notes
// RULE_01 - Register writable as any file destination.
// RULE_02 - Flag-updating writes skip the arithmetic flags; code masks only the flags that the instruction updates.
// RULE_03 - Reset-status flags never written by instructions.
// RULE_04 - Clear-file zeroes upper three, sets zero.
// RULE_05 - Decoded at 03h and 83h alike.
// RULE_06 - Bank bits select 128-byte direct bank.
// RULE_07 - Software keeps reserved top bits at zero.
// RULE_08 - Subtraction carries act as inverted borrows.
// RULE_09 - Timeout flag set by power-up, kick, sleep.
// RULE_10 - Power-on gives bank low 0, reset flags 1.
// RULE_11 - Software prefers flag-neutral ops for changes.
// RULE_12 - Powerdown flag set by power-up, kick; sleep clears.
// RULE_13 - Zero flag tracks operation result zero.
// RULE_14 - Nibble and full carries; rotate loads carry.
module cpu_status_flag_register
    import status_reg_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire file_write_t   file_wr,
    input  wire alu_flags_t    alu_flags,
    input  wire status_event_t events,
    input  wire logic [7:0]    read_addr,
    input  wire logic [6:0]    direct_offset,
    input  wire logic [7:0]    alu_a,
    input  wire logic [7:0]    alu_b,
    input  wire logic          alu_subtract,
    input  wire logic          alu_rotate,
    input  wire logic          alu_rotate_left,
    input  wire logic          alu_logic_op,
    input  wire logic [7:0]    alu_logic_result,
    output logic      [7:0]    alu_result,
    output logic               calc_zero,
    output logic               calc_nibble_carry,
    output logic               calc_carry,
    output logic      [7:0]    read_data,
    output logic               read_hit,
    output logic      [7:0]    status_value,
    output logic      [8:0]    direct_addr
);

    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic [7:0] read_data_r;
    logic [7:0] read_data_nxt;
    logic       read_hit_r;
    logic       read_hit_nxt;
    logic       wr_hit;
    logic       rd_hit;
    logic [7:0] write_mask;

    // Shared ALU flag calculation feeds back through alu_flags from the execution logic.
    flag_calc u_flag_calc (
        .op_a         (alu_a),
        .op_b         (alu_b),
        .subtract     (alu_subtract),
        .rotate       (alu_rotate),
        .rotate_left  (alu_rotate_left),
        .logic_op     (alu_logic_op),
        .logic_result (alu_logic_result),
        .result       (alu_result),
        .zero         (calc_zero),
        .nibble_carry (calc_nibble_carry),
        .carry        (calc_carry)
    );

    // Both banks reach one physical register, so only the low seven bits are compared.
    assign wr_hit = file_wr.write_en && (file_wr.addr[6:0] == STATUS_FILE_INDEX); // RULE_05
    assign rd_hit = (read_addr[6:0] == STATUS_FILE_INDEX); // RULE_05

    // Next register value: instruction write first, then flag logic and events on top.
    always_comb
    begin
        // Reset-status bits are never in the instruction write mask.
        write_mask = ~RESET_FLAG_MASK; // RULE_03
        if (alu_flags.update_zero)
        begin
            write_mask[BIT_ZERO] = 1'b0; // RULE_02
        end
        if (alu_flags.update_nibble)
        begin
            write_mask[BIT_NIBBLE_CARRY] = 1'b0; // RULE_02
        end
        if (alu_flags.update_carry)
        begin
            write_mask[BIT_CARRY] = 1'b0; // RULE_02
        end
        status_nxt = status_r;
        if (wr_hit && file_wr.clear_file_op)
        begin
            // Only the upper three bits clear; zero flag is forced set.
            status_nxt             = status_r & ~UPPER_THREE_MASK; // RULE_04
            status_nxt[BIT_ZERO]   = 1'b1; // RULE_04
        end
        else if (wr_hit)
        begin
            status_nxt = (status_r & ~write_mask) | (file_wr.data & write_mask); // RULE_01
        end
        if (alu_flags.update_zero && !(wr_hit && file_wr.clear_file_op))
        begin
            status_nxt[BIT_ZERO] = alu_flags.zero; // RULE_13
        end
        if (alu_flags.update_nibble)
        begin
            status_nxt[BIT_NIBBLE_CARRY] = alu_flags.nibble_carry; // RULE_14
        end
        if (alu_flags.update_carry)
        begin
            status_nxt[BIT_CARRY] = alu_flags.carry; // RULE_14
        end
        // A timeout outranks a kick in the same cycle so the event is never lost.
        if (events.watchdog_timeout)
        begin
            status_nxt[BIT_WATCHDOG] = 1'b0; // RULE_09
        end
        else if (events.watchdog_kick_op || events.sleep_op)
        begin
            status_nxt[BIT_WATCHDOG] = 1'b1; // RULE_09
        end
        if (events.sleep_op)
        begin
            status_nxt[BIT_POWERDOWN] = 1'b0; // RULE_12
        end
        else if (events.watchdog_kick_op)
        begin
            status_nxt[BIT_POWERDOWN] = 1'b1; // RULE_12
        end
        read_hit_nxt  = rd_hit;
        read_data_nxt = rd_hit ? status_r : 8'h00;
    end

    // Power-on state; arithmetic flags have no defined value, so they start at zero.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            status_r    <= STATUS_RESET_VALUE; // RULE_10
            read_data_r <= 8'h00;
            read_hit_r  <= 1'b0;
        end
        else
        begin
            status_r    <= status_nxt;
            read_data_r <= read_data_nxt;
            read_hit_r  <= read_hit_nxt;
        end
    end

    assign read_data    = read_data_r;
    assign read_hit     = read_hit_r;
    assign status_value = status_r;
    // Bank bits prefix the 7-bit direct offset; the page bit stays out of direct addressing.
    assign direct_addr  = {status_r[BIT_BANK_HIGH], status_r[BIT_BANK_LOW], direct_offset}; // RULE_06

    // Reset-status bits must not follow a plain instruction write.
    property ro_flags_p;
        @(posedge clk) disable iff (!rstn)
        (wr_hit && !file_wr.clear_file_op && !events.watchdog_kick_op && !events.sleep_op
            && !events.watchdog_timeout) |=> (status_r[4:3] == $past(status_r[4:3]));
    endproperty
    ro_flags_a: assert property (ro_flags_p) else $error("Reset flags changed by write."); // RULE_03

    sequence clear_issue_s;
        wr_hit && file_wr.clear_file_op && !alu_flags.update_nibble && !alu_flags.update_carry
            && !events.watchdog_kick_op && !events.sleep_op && !events.watchdog_timeout;
    endsequence
    clear_file_a: assert property (@(posedge clk) disable iff (!rstn) clear_issue_s |=> // RULE_04
        (status_r[7:5] == 3'b000) && status_r[BIT_ZERO] && (status_r[4:0] & 5'h1B) == ($past(status_r[4:0]) & 5'h1B))
        else $error("Clear of status register wrong.");

    flag_priority_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_02
        (wr_hit && !file_wr.clear_file_op && alu_flags.update_carry) |=> status_r[BIT_CARRY] == $past(alu_flags.carry))
        else $error("Instruction write overrode carry.");

    plain_write_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_01
        (wr_hit && !file_wr.clear_file_op) |=> status_r[7:5] == $past(file_wr.data[7:5]))
        else $error("Status write not stored.");

    timeout_clear_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
        events.watchdog_timeout |=> !status_r[BIT_WATCHDOG])
        else $error("Timeout did not clear flag.");

    sleep_flags_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_12
        (events.sleep_op && !events.watchdog_timeout) |=> status_r[BIT_WATCHDOG] && !status_r[BIT_POWERDOWN])
        else $error("Sleep flags wrong.");

    mirror_read_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_05
        (read_addr == STATUS_ADDR_BANK1) |=> read_hit && read_data == $past(status_r))
        else $error("Mirror read wrong.");

    bank_addr_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_06
        direct_addr[8:7] == status_r[6:5])
        else $error("Bank select wrong.");

    sub_borrow_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_08
        (alu_subtract && !alu_rotate && alu_a == alu_b) |-> calc_carry && calc_nibble_carry && calc_zero)
        else $error("Equal subtract borrow wrong.");

endmodule

/* File: status_reg_pkg.sv */
/*
 * Package for the CPU flag and bank-select register.
 * It holds the file addresses, the bit positions, the reset values and the carrier types.
 * It assumes a 9-bit data-memory address space of four banks of 128 bytes.
 */
package status_reg_pkg;

    localparam logic [6:0] STATUS_FILE_INDEX   = 7'h03;
    localparam logic [7:0] STATUS_ADDR_BANK0   = 8'h03;
    localparam logic [7:0] STATUS_ADDR_BANK1   = 8'h83;
    localparam int         BIT_CARRY           = 0;
    localparam int         BIT_NIBBLE_CARRY    = 1;
    localparam int         BIT_ZERO            = 2;
    localparam int         BIT_POWERDOWN       = 3;
    localparam int         BIT_WATCHDOG        = 4;
    localparam int         BIT_BANK_LOW        = 5;
    localparam int         BIT_BANK_HIGH       = 6;
    localparam int         BIT_INDIRECT_PAGE   = 7;
    localparam int         BANK_SHIFT          = 7;
    localparam logic [7:0] STATUS_RESET_VALUE  = 8'h18;
    localparam logic [7:0] UPPER_THREE_MASK    = 8'hE0;
    localparam logic [7:0] ARITH_FLAG_MASK     = 8'h07;
    localparam logic [7:0] RESET_FLAG_MASK     = 8'h18;

    // Flag results produced by the ALU for one instruction.
    typedef struct packed {
        logic update_zero;
        logic update_nibble;
        logic update_carry;
        logic zero;
        logic nibble_carry;
        logic carry;
    } alu_flags_t;

    // Register-file write request from the execution logic.
    typedef struct packed {
        logic       write_en;
        logic       clear_file_op;
        logic [7:0] addr;
        logic [7:0] data;
    } file_write_t;

    // One-cycle reset-status events.
    typedef struct packed {
        logic watchdog_kick_op;
        logic sleep_op;
        logic watchdog_timeout;
    } status_event_t;

endpackage

/* File: flag_calc.sv */
/*
 * ALU flag calculator for add, subtract, rotate and logic results.
 * It assumes the execution logic chooses which flags an instruction updates.
 */
module flag_calc
    import status_reg_pkg::*;
(
    input  wire logic [7:0] op_a,
    input  wire logic [7:0] op_b,
    input  wire logic       subtract,
    input  wire logic       rotate,
    input  wire logic       rotate_left,
    input  wire logic       logic_op,
    input  wire logic [7:0] logic_result,
    output logic      [7:0] result,
    output logic            zero,
    output logic            nibble_carry,
    output logic            carry
);

    logic [7:0] addend;
    logic [4:0] low_sum;
    logic [8:0] full_sum;

    // Subtraction adds the two's complement, so carry reads as inverted borrow.
    always_comb
    begin
        addend   = subtract ? 8'(~op_b) : op_b; // RULE_08
        low_sum  = 5'({1'b0, op_a[3:0]}) + 5'({1'b0, addend[3:0]}) + 5'({4'h0, subtract});
        full_sum = 9'({1'b0, op_a}) + 9'({1'b0, addend}) + 9'({8'h00, subtract});
        result       = full_sum[7:0];
        nibble_carry = low_sum[4]; // RULE_14
        carry        = full_sum[8]; // RULE_14
        if (rotate)
        begin
            // Rotation goes through carry; the shifted-out source bit lands in carry.
            result = rotate_left ? {op_a[6:0], op_b[0]} : {op_b[0], op_a[7:1]};
            carry  = rotate_left ? op_a[7] : op_a[0]; // RULE_14
        end
        else if (logic_op)
        begin
            result = logic_result;
        end
        zero = (result == 8'h00); // RULE_13
    end

endmodule

/* File: exec_model.sv */
/* Execution-logic model that drives file writes, flag results and reset-status events.
   It assumes its caller enters issue just after a rising clock edge. */
module exec_model
    import status_reg_pkg::*;
(
    input  wire logic    clk,
    output file_write_t  file_wr,
    output alu_flags_t   alu_flags,
    output status_event_t events
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle until the first instruction.
    initial
    begin
        file_wr = '0;
        alu_flags = '0;
        events = '0;
    end

    // One instruction for one cycle; released address, data and flag values show inverted stale values, events go to zero.
    // The request is built locally so each port is assigned once per time step.
    task automatic issue(input file_write_t fw, input alu_flags_t fl, input status_event_t ev);
        file_write_t req;
        req = fw;
        req.data = fw.data & 8'h3F;
        file_wr = req;
        alu_flags = fl;
        events = ev;
        @(posedge clk);
        #1;
        req = ~req;
        req.write_en = 1'b0;
        req.clear_file_op = 1'b0;
        file_wr = req;
        alu_flags = ~fl & 6'h07;
        events = '0;
    endtask
endmodule

/* File: cpu_status_flag_register_tb.sv */
/* Self-checking bench for the flag and bank-select register.
   It assumes the exec_model partner and the one-cycle registered read port. */
module cpu_status_flag_register_tb
    import status_reg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] read_addr = 8'h04, alu_a = '0, alu_b = '0, alu_logic_result = '0, alu_result, read_data, status_value;
    logic [6:0] direct_offset = '0;
    logic alu_subtract = 0, alu_rotate = 0, alu_rotate_left = 0, alu_logic_op = 0;
    logic calc_zero, calc_nibble_carry, calc_carry, read_hit;
    logic [8:0] direct_addr, sum;
    file_write_t file_wr;
    alu_flags_t alu_flags;
    status_event_t events;
    logic [7:0] st, exp_q[$];
    logic [8:0] exp_rd;
    int bad_count = 0, num_checks = 0;

    always #2.5 clk = ~clk;

    exec_model i_exec (.clk(clk), .file_wr(file_wr), .alu_flags(alu_flags), .events(events));

    cpu_status_flag_register i_dut (.clk(clk), .rstn(rstn), .file_wr(file_wr), .alu_flags(alu_flags),
        .events(events), .read_addr(read_addr), .direct_offset(direct_offset), .alu_a(alu_a),
        .alu_b(alu_b), .alu_subtract(alu_subtract), .alu_rotate(alu_rotate),
        .alu_rotate_left(alu_rotate_left), .alu_logic_op(alu_logic_op),
        .alu_logic_result(alu_logic_result), .alu_result(alu_result), .calc_zero(calc_zero),
        .calc_nibble_carry(calc_nibble_carry), .calc_carry(calc_carry), .read_data(read_data),
        .read_hit(read_hit), .status_value(status_value), .direct_addr(direct_addr));

    task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Expected register after one instruction; later events take priority.
    function automatic logic [7:0] next_st(logic [7:0] s, file_write_t fw, alu_flags_t fl, status_event_t ev);
        logic [7:0] n;
        logic clr;
        n = s;
        clr = fw.write_en && fw.clear_file_op && fw.addr[6:0] == 7'h03;
        if (fw.write_en && fw.addr[6:0] == 7'h03)
            n = clr ? ((s & 8'h1B) | 8'h04) : (((fw.data & 8'h3F) & ~8'h18) | (s & 8'h18));
        if (fl.update_zero && !clr)
            n[2] = fl.zero;
        if (fl.update_nibble)
            n[1] = fl.nibble_carry;
        if (fl.update_carry)
            n[0] = fl.carry;
        if (ev.watchdog_kick_op)
            n[4:3] = 2'b11;
        if (ev.sleep_op)
            n[4:3] = 2'b10;
        if (ev.watchdog_timeout)
            n[4] = 1'b0;
        return n;
    endfunction

    // Reads note their expectation; the watcher compares when the answer shows.
    task automatic read_back(input logic [7:0] a);
        read_addr = a;
        if (a[6:0] == 7'h03)
            exp_q.push_back(st);
        @(posedge clk);
        #1;
        read_addr = 8'h04;
    endtask

    task automatic do_op(input file_write_t fw, input alu_flags_t fl, input status_event_t ev);
        st = next_st(st, fw, fl, ev);
        i_exec.issue(fw, fl, ev);
        check("status_value", {1'b0, status_value}, {1'b0, st});
        read_back(fw.addr[7] ? 8'h03 : 8'h83);
    endtask

    // Watcher: an unexpected answer finds an empty queue and counts as a mismatch.
    always @(posedge clk)
    begin
        if (rstn && read_hit === 1'b1)
        begin
            // An answer with no note gets an expectation that no 8-bit value can match.
            exp_rd = exp_q.size() ? {1'b0, exp_q.pop_front()} : 9'h100;
            check("read_data", {1'b0, read_data}, exp_rd);
        end
    end

    // Hang guard: far longer than the whole sequence.
    initial
    begin
        #20000;
        bad_count++;
        wrap_up();
    end

    initial
    begin
        void'($urandom(32'h7EFF9D79));
        repeat (5) @(posedge clk);
        #1;
        rstn = 1'b1;
        st = 8'h18;
        read_back(8'h03);
        do_op('{1, 0, 8'h83, 8'hFF}, '0, '0);
        direct_offset = 7'($urandom);
        #1 check("direct_addr", direct_addr, {st[6:5], direct_offset});
        read_back(8'h05);
        for (int k = 0; k < 8; k++)
            do_op('{1, 0, 8'h03, 8'($urandom)}, '0, 3'(k));
        for (int i = 0; i < 16; i++)
        begin
            do_op('{1, i % 4 == 3, (i % 2) ? 8'h83 : 8'($urandom), 8'($urandom)}, 6'($urandom), '0);
            check("direct_addr", direct_addr, {st[6:5], direct_offset});
        end
        for (int i = 0; i < 20; i++)
        begin
            alu_a = 8'($urandom);
            alu_b = (i < 5) ? ((i % 5 == 0) ? -alu_a : alu_a) : 8'($urandom);
            alu_logic_result = 8'($urandom);
            {alu_subtract, alu_rotate, alu_rotate_left, alu_logic_op} = 4'({i % 5 == 1, i % 5 == 2 || i % 5 == 3, i % 5 == 2, i % 5 == 4});
            sum = alu_subtract ? ({1'b0, alu_a} + {1'b0, ~alu_b} + 9'h001) : ({1'b0, alu_a} + {1'b0, alu_b});
            // Each operand set spans a clock edge so the design's assertions see it too.
            @(posedge clk);
            #1;
            if (i % 5 < 2)
            begin
                check("alu_result", alu_result, sum[7:0]);
                check("calc_carry", calc_carry, sum[8]);
                check("calc_nibble_carry", calc_nibble_carry, alu_subtract ? alu_a[3:0] >= alu_b[3:0] : 5'(alu_a[3:0]) + 5'(alu_b[3:0]) > 5'h0F);
                check("calc_zero", calc_zero, sum[7:0] == 8'h00);
            end
            else if (i % 5 < 4)
            begin
                check("alu_result", alu_result, alu_rotate_left ? {alu_a[6:0], alu_b[0]} : {alu_b[0], alu_a[7:1]});
                check("calc_carry", calc_carry, alu_rotate_left ? alu_a[7] : alu_a[0]);
            end
            else
                check("calc_zero", calc_zero, alu_logic_result == 8'h00);
        end
        do_op('{1, 0, 8'h03, 8'h20}, '0, 3'h1);
        // Let the last read answer before reset wipes it, or its note would go stale.
        @(posedge clk);
        #1;
        rstn = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rstn = 1'b1;
        st = 8'h18;
        read_back(8'h83);
        repeat (3) @(posedge clk);
        check("pending_reads", exp_q.size(), 9'h000);
        wrap_up();
    end
endmodule
